// File: core/touch_scan_pkg.sv
// Constants, decode functions and scan states for the touch scan block.
// Assumes a 50 MHz mclk; all long times are counted in 10 us ticks.
package touch_scan_pkg;

  localparam int NCH = 6;

  localparam logic [7:0] OFF_TIMING   = 8'h22;
  localparam logic [7:0] OFF_HOLD     = 8'h23;
  localparam logic [7:0] OFF_AVG      = 8'h24;
  localparam logic [7:0] OFF_RECAL    = 8'h26;
  localparam logic [7:0] OFF_STATUS   = 8'h30;
  localparam logic [7:0] OFF_HOLDFLAG = 8'h31;

  localparam logic [7:0] RST_TIMING = 8'ha4;
  localparam logic [7:0] RST_HOLD   = 8'h07;
  localparam logic [7:0] RST_AVG    = 8'h39;
  localparam logic [7:0] RST_RECAL  = 8'h00;

  localparam int LIMIT_MSB = 7;
  localparam int LIMIT_LSB = 4;
  localparam int RPT_MSB   = 3;
  localparam int RPT_LSB   = 0;
  localparam int PRESS_MSB = 3;
  localparam int PRESS_LSB = 0;
  localparam int AVG_MSB   = 6;
  localparam int AVG_LSB   = 4;
  localparam int SAMP_MSB  = 3;
  localparam int SAMP_LSB  = 2;
  localparam int CYC_MSB   = 1;
  localparam int CYC_LSB   = 0;

  localparam int CLK_HZ          = 50_000_000;
  localparam int TICK_US         = 10;
  localparam int TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TICKS_PER_MS    = 1000 / TICK_US;
  localparam int STEP_MS         = 35;
  localparam int STEP_TICKS      = STEP_MS * TICKS_PER_MS;
  localparam int SAMP_BASE_US    = 320;
  localparam int SAMP_BASE_TICKS = SAMP_BASE_US / TICK_US;
  localparam int RECAL_MS        = 600;
  localparam int RECAL_TICKS_DEF = RECAL_MS * TICKS_PER_MS;

  localparam int LIMIT_MS [16] = '{560, 840, 1120, 1400, 1680, 2240, 2800,
    3360, 3920, 4480, 5600, 6720, 7840, 8906, 10080, 11200};

  typedef enum logic [1:0] {
    SCAN_IDLE   = 2'b00,
    SCAN_SEEK   = 2'b01,
    SCAN_SAMPLE = 2'b11
  } scan_t;

  function automatic logic [20:0] limit_ticks(input logic [3:0] code);
    return 21'(LIMIT_MS[code] * TICKS_PER_MS);
  endfunction

  function automatic logic [20:0] step_ticks(input logic [3:0] code);
    return 21'((int'(code) + 1) * STEP_TICKS);
  endfunction

  function automatic logic [8:0] samp_ticks(input logic [1:0] code);
    return 9'(SAMP_BASE_TICKS << code);
  endfunction

endpackage

// File: core/touch_scan_timing_config.sv
// Scan timing, averaging, hold timing and forced recalibration for six
// touch inputs. Assumes pads arrive asynchronously on touch_raw; all other
// inputs come from logic on mclk. Registers sit on a plain strobe port.
//
// Functional notes
// - Bits 7:4 of timing register pick how long a touch may be held.
// - Held limit decodes through a sixteen-entry table, 560 to 11200 ms.
// - Held-limit recalibration happens only while the held-limit enable is set.
// - Bits 3:0 pick repeat interval as (n+1) times 35 ms.
// - Second register bits 3:0 hold press threshold, (n+1) times 35 ms.
// - With repeat enabled, touch longer than threshold is press-and-hold, else a plain touch.
// - Press-and-hold with repeat raises event at detect and every interval.
// - Samples per channel per cycle are two to the averaging code.
// - Samples of one channel run back to back, then get averaged.
// - Averaging, sample time and cycle period act only in Active state.
// - Sample time code selects 320 us, 640 us, 1.28 ms or 2.56 ms.
// - Cycle period code selects 35, 70, 105 or 140 ms.
// - Channels sample at cycle start, then idle in low power.
// - Sampling longer than the period stretches the cycle.
// - Only enabled inputs sample; cycle length ignores enable count.
// - Writing a request bit starts recalibration of that input.
// - During recalibration presses are not reported, base count invalid.
// - A press during recalibration makes it invalid.
// - A successful recalibration updates the 10-bit calibration value.
// - Request bit clears itself after a successful recalibration.
// - Held limit and repeat interval are shared by all six inputs.
`timescale 1ns/1ps

module touch_scan_timing_config
  import touch_scan_pkg::*;
#(
  parameter int TICK_CYC    = TICK_CYCLES,
  parameter int RECAL_TICKS = RECAL_TICKS_DEF
) (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  active_state,
  input  wire logic                  held_limit_enable,
  input  wire logic [NCH-1:0]        input_enable,
  input  wire logic [NCH-1:0]        repeat_enable,
  input  wire logic [NCH-1:0]        touch_raw,
  input  wire logic [9:0]            sample_value,
  output logic                       sample_busy,
  output logic      [2:0]            sample_channel,
  output logic                       low_power,
  output logic                       result_valid,
  output logic      [2:0]            result_channel,
  output logic      [9:0]            result_value,
  output logic      [NCH-1:0]        press_irq,
  output logic      [NCH-1:0]        touch_event,
  output logic      [NCH-1:0]        hold_active,
  output logic      [NCH-1:0]        recal_busy,
  output logic      [NCH-1:0][9:0]   calibration_value
);

  if (TICK_CYC < 1 || TICK_CYC > 512) begin : g_tick_chk
    $error("TICK_CYC must be 1 to 512");
  end
  if (RECAL_TICKS < 1 || RECAL_TICKS > 65535) begin : g_recal_chk
    $error("RECAL_TICKS must be 1 to 65535");
  end

  localparam logic [8:0]  TICK_LAST  = 9'(TICK_CYC - 1);
  localparam logic [15:0] RECAL_LAST = 16'(RECAL_TICKS - 1);
  localparam logic [2:0]  CH_END     = 3'(NCH);

  typedef struct packed {
    logic [7:0]            timing;
    logic [3:0]            press;
    logic [6:0]            avgcfg;
    logic [NCH-1:0]        req;
    logic [7:0]            rdata;
    logic [NCH-1:0]        sync1;
    logic [NCH-1:0]        sync2;
    logic [NCH-1:0]        touched;
    logic [8:0]            tick_cnt;
    logic                  tick;
    logic [NCH-1:0][20:0]  hold_cnt;
    logic [NCH-1:0][20:0]  rpt_cnt;
    logic [NCH-1:0]        is_hold;
    logic [NCH-1:0]        irq;
    logic [NCH-1:0]        tap;
    scan_t                 scan;
    logic [2:0]            ch;
    logic [7:0]            samp_n;
    logic [8:0]            samp_t;
    logic [15:0]           cyc_t;
    logic [16:0]           acc;
    logic                  busy;
    logic                  low_power;
    logic                  res_valid;
    logic [2:0]            res_ch;
    logic [9:0]            res_val;
    logic [NCH-1:0][9:0]   last_res;
    logic [NCH-1:0][9:0]   cal_val;
    logic [NCH-1:0]        run;
    logic [NCH-1:0]        bad;
    logic [15:0]           recal_t;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic [20:0]    limit_t;
  logic [20:0]    rpt_t;
  logic [20:0]    press_t;
  logic [20:0]    cyc_p;
  logic [8:0]     samp_p;
  logic [2:0]     avg_code;
  logic [7:0]     avg_last;
  logic [16:0]    sum;
  logic [NCH-1:0] touch_now;
  logic [NCH-1:0] held_fire;

  assign limit_t   = limit_ticks(st_ff.timing[LIMIT_MSB:LIMIT_LSB]);
  assign rpt_t     = step_ticks(st_ff.timing[RPT_MSB:RPT_LSB]);
  assign press_t   = step_ticks(st_ff.press[PRESS_MSB:PRESS_LSB]);
  assign cyc_p     = step_ticks({2'h0, st_ff.avgcfg[CYC_MSB:CYC_LSB]});
  assign samp_p    = samp_ticks(st_ff.avgcfg[SAMP_MSB:SAMP_LSB]);
  // sample count is two to the code
  assign avg_code  = st_ff.avgcfg[AVG_MSB:AVG_LSB];
  assign avg_last  = 8'((9'h001 << avg_code) - 9'h001);
  assign sum       = st_ff.acc + 17'(sample_value);
  // no presses seen while recalibrating
  // Pending request blanks too, so a spoiled rerun never reports a press
  assign touch_now = st_ff.sync2 & input_enable & ~(st_ff.run | st_ff.req);

  always_comb begin
    logic [NCH-1:0] clr_m;
    clr_m  = '0;
    nxt_st = st_ff;
    nxt_st.irq       = '0;
    nxt_st.tap       = '0;
    nxt_st.res_valid = 1'b0;
    nxt_st.rdata     = 8'h00;
    held_fire        = '0;

    nxt_st.sync1 = touch_raw;
    nxt_st.sync2 = st_ff.sync1;

    if (st_ff.tick_cnt == TICK_LAST) begin
      nxt_st.tick_cnt = 9'h000;
      nxt_st.tick     = 1'b1;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 9'h001;
      nxt_st.tick     = 1'b0;
    end

    nxt_st.touched = touch_now;
    for (int i = 0; i < NCH; i++) begin
      if (touch_now[i] && !st_ff.touched[i]) begin
        nxt_st.irq[i]      = 1'b1;
        nxt_st.hold_cnt[i] = '0;
        nxt_st.rpt_cnt[i]  = '0;
        nxt_st.is_hold[i]  = 1'b0;
      end else if (touch_now[i]) begin
        if (st_ff.tick) begin
          if (st_ff.hold_cnt[i] != '1) begin
            nxt_st.hold_cnt[i] = st_ff.hold_cnt[i] + 21'h1;
          end
          // repeat while held
          // Shortened interval wraps at once instead of running to overflow
          if (st_ff.rpt_cnt[i] >= rpt_t - 21'h1) begin
            nxt_st.rpt_cnt[i] = '0;
            nxt_st.irq[i]     = st_ff.is_hold[i];
          end else begin
            nxt_st.rpt_cnt[i] = st_ff.rpt_cnt[i] + 21'h1;
          end
          // held too long asks for recalibration
          held_fire[i] = held_limit_enable &&
                         st_ff.hold_cnt[i] == limit_t;
        end
        if (repeat_enable[i] && st_ff.hold_cnt[i] > press_t) begin
          nxt_st.is_hold[i] = 1'b1;
        end
      end else begin
        // short release is a plain touch
        nxt_st.tap[i]     = st_ff.touched[i] & ~st_ff.is_hold[i];
        nxt_st.is_hold[i] = 1'b0;
      end
    end

    // Cycle timer saturates so a stretched cycle restarts at once
    if (st_ff.tick && st_ff.cyc_t != '1) begin
      nxt_st.cyc_t = st_ff.cyc_t + 16'h0001;
    end

    unique case (st_ff.scan)
      SCAN_IDLE: begin
        // new cycle only when active and period over
        if (active_state && {5'h00, st_ff.cyc_t} >= cyc_p) begin
          nxt_st.scan  = SCAN_SEEK;
          nxt_st.ch    = 3'h0;
          nxt_st.cyc_t = 16'h0000;
        end
      end
      SCAN_SEEK: begin
        if (st_ff.ch == CH_END) begin
          nxt_st.scan = SCAN_IDLE;
        end else if (input_enable[st_ff.ch]) begin
          nxt_st.scan   = SCAN_SAMPLE;
          nxt_st.samp_t = 9'h000;
          nxt_st.samp_n = 8'h00;
          nxt_st.acc    = 17'h00000;
        end else begin
          nxt_st.ch = st_ff.ch + 3'h1;
        end
      end
      SCAN_SAMPLE: begin
        if (st_ff.tick) begin
          if (st_ff.samp_t == samp_p - 9'h001) begin
            // accumulate back to back, then average
            nxt_st.samp_t = 9'h000;
            nxt_st.acc    = sum;
            if (st_ff.samp_n == avg_last) begin
              nxt_st.res_valid          = 1'b1;
              nxt_st.res_ch             = st_ff.ch;
              nxt_st.res_val            = 10'(sum >> avg_code);
              nxt_st.last_res[st_ff.ch] = 10'(sum >> avg_code);
              nxt_st.ch                 = st_ff.ch + 3'h1;
              nxt_st.scan               = SCAN_SEEK;
            end else begin
              nxt_st.samp_n = st_ff.samp_n + 8'h01;
            end
          end else begin
            nxt_st.samp_t = st_ff.samp_t + 9'h001;
          end
        end
      end
    endcase
    nxt_st.busy      = (nxt_st.scan == SCAN_SAMPLE);
    nxt_st.low_power = (nxt_st.scan == SCAN_IDLE);

    if (|st_ff.run) begin
      nxt_st.bad = st_ff.bad | (st_ff.run & st_ff.sync2);
      if (st_ff.tick) begin
        if (st_ff.recal_t == RECAL_LAST) begin
          for (int i = 0; i < NCH; i++) begin
            // good runs store value and clear request
            if (st_ff.run[i] && !nxt_st.bad[i]) begin
              nxt_st.cal_val[i] = st_ff.last_res[i];
              clr_m[i]          = 1'b1;
            end
          end
          nxt_st.run = '0;
        end else begin
          nxt_st.recal_t = st_ff.recal_t + 16'h0001;
        end
      end
    end else if (|st_ff.req) begin
      nxt_st.run     = st_ff.req;
      nxt_st.bad     = '0;
      nxt_st.recal_t = 16'h0000;
    end

    // Software write and held-limit set both beat the automatic clear
    nxt_st.req = st_ff.req & ~clr_m;
    if (reg_wr) begin
      unique case (reg_addr)
        OFF_TIMING: nxt_st.timing = reg_wdata;
        OFF_HOLD:   nxt_st.press  = reg_wdata[3:0];
        OFF_AVG:    nxt_st.avgcfg = reg_wdata[6:0];
        OFF_RECAL:  nxt_st.req    = reg_wdata[NCH-1:0];
        default: ;
      endcase
    end
    nxt_st.req = nxt_st.req | held_fire;

    if (reg_rd) begin
      unique case (reg_addr)
        OFF_TIMING:   nxt_st.rdata = st_ff.timing;
        OFF_HOLD:     nxt_st.rdata = {4'h0, st_ff.press};
        OFF_AVG:      nxt_st.rdata = {1'b0, st_ff.avgcfg};
        OFF_RECAL:    nxt_st.rdata = {2'h0, st_ff.req};
        OFF_STATUS:   nxt_st.rdata = {st_ff.busy, st_ff.low_power, st_ff.run};
        OFF_HOLDFLAG: nxt_st.rdata = {2'h0, st_ff.is_hold};
        default:      nxt_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_ff        <= '0;
      st_ff.timing <= RST_TIMING;
      st_ff.press  <= RST_HOLD[3:0];
      st_ff.avgcfg <= RST_AVG[6:0];
      st_ff.req    <= RST_RECAL[NCH-1:0];
      st_ff.cyc_t  <= 16'hffff;
      st_ff.scan   <= SCAN_IDLE;
      st_ff.low_power <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata         = st_ff.rdata;
  assign sample_busy       = st_ff.busy;
  assign sample_channel    = st_ff.ch;
  assign low_power         = st_ff.low_power;
  assign result_valid      = st_ff.res_valid;
  assign result_channel    = st_ff.res_ch;
  assign result_value      = st_ff.res_val;
  assign press_irq         = st_ff.irq;
  assign touch_event       = st_ff.tap;
  assign hold_active       = st_ff.is_hold;
  assign recal_busy        = st_ff.run;
  assign calibration_value = st_ff.cal_val;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence recal_end_s;
    (|st_ff.run) && st_ff.tick && st_ff.recal_t == RECAL_LAST;
  endsequence

  sequence touch_rise_s;
    touch_now[0] && !st_ff.touched[0];
  endsequence

  a_held_sets_req: assert property (
    (|held_fire) |=> ((st_ff.req & $past(held_fire)) == $past(held_fire))
  ) else $error("held limit did not raise request");

  a_held_gated: assert property (
    !held_limit_enable |-> held_fire == '0
  ) else $error("held recalibration while disabled");

  a_rpt_bounded: assert property (
    st_ff.touched[0] |-> st_ff.rpt_cnt[0] < rpt_t
  ) else $error("repeat counter past interval");

  a_hold_class: assert property (
    $rose(st_ff.is_hold[0]) |-> $past(st_ff.hold_cnt[0]) > $past(press_t)
  ) else $error("press-and-hold set too early");

  a_tap_short: assert property (
    st_ff.tap[0] |-> !$past(st_ff.is_hold[0])
  ) else $error("plain touch after hold");

  a_press_event: assert property (
    touch_rise_s |=> st_ff.irq[0]
  ) else $error("no event on touch detect");

  a_avg_count: assert property (
    st_ff.res_valid |-> $past(st_ff.samp_n) == $past(avg_last)
  ) else $error("result after wrong sample count");

  a_idle_inactive: assert property (
    (st_ff.scan == SCAN_IDLE && !active_state) |=> st_ff.scan == SCAN_IDLE
  ) else $error("scan started outside active state");

  a_cycle_start: assert property (
    $fell(st_ff.low_power) |-> $past({5'h00, st_ff.cyc_t}) >= $past(cyc_p)
  ) else $error("cycle started before period");

  a_enabled_only: assert property (
    (st_ff.scan == SCAN_SAMPLE) |-> input_enable[st_ff.ch]
  ) else $error("disabled input sampled");

  a_recal_blank: assert property (
    ($past(st_ff.run) & st_ff.irq) == '0
  ) else $error("press reported while recalibrating");

  a_recal_done: assert property (
    recal_end_s |=> st_ff.run == '0 ##1 (st_ff.run == '0 || |st_ff.req)
  ) else $error("recalibration did not finish");

endmodule // touch_scan_timing_config

// File: sim/test_touch_scan_timing_config.sv
// Self-checking bench for the touch scan timing and recalibration block.
// Assumes TICK_CYC 2 and RECAL_TICKS 10, so 1 ms is 200 mclk cycles.
`timescale 1ns/1ps

module test_touch_scan_timing_config;
  import touch_scan_pkg::*;
  localparam int LIMIT = 90000;
  logic                mclk;
  logic                reset;
  logic [7:0]          reg_addr;
  logic [7:0]          reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [7:0]          reg_rdata;
  logic                active_state;
  logic                held_limit_enable;
  logic [NCH-1:0]      input_enable;
  logic [NCH-1:0]      repeat_enable;
  logic [NCH-1:0]      touch_raw;
  logic [NCH-1:0]      pad_press;
  logic [9:0]          sample_value;
  logic                sample_busy;
  logic [2:0]          sample_channel;
  logic                low_power;
  logic                result_valid;
  logic [2:0]          result_channel;
  logic [9:0]          result_value;
  logic [NCH-1:0]      press_irq;
  logic [NCH-1:0]      touch_event;
  logic [NCH-1:0]      hold_active;
  logic [NCH-1:0]      recal_busy;
  logic [NCH-1:0][9:0] calibration_value;
  logic [7:0]          rv;
  int                  n_errors;
  int                  n_checks;
  int                  cyc;
  int                  n_irq;
  int                  n_tev;
  int                  n_blk;
  int                  t0;
  int                  t1;
  int                  k;

  touch_scan_timing_config #(.TICK_CYC(2), .RECAL_TICKS(10))
    touch_scan_timing_config_inst (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .active_state(active_state),
    .held_limit_enable(held_limit_enable), .input_enable(input_enable),
    .repeat_enable(repeat_enable), .touch_raw(touch_raw),
    .sample_value(sample_value), .sample_busy(sample_busy),
    .sample_channel(sample_channel), .low_power(low_power),
    .result_valid(result_valid), .result_channel(result_channel),
    .result_value(result_value), .press_irq(press_irq),
    .touch_event(touch_event), .hold_active(hold_active),
    .recal_busy(recal_busy), .calibration_value(calibration_value));

  touch_pad_model touch_pad_model_inst (
    .mclk(mclk), .pad_press(pad_press), .sample_busy(sample_busy),
    .sample_channel(sample_channel), .touch_raw(touch_raw),
    .sample_value(sample_value));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (|press_irq) n_irq++;
    if (|touch_event) n_tev++;
    if (|(press_irq & recal_busy)) n_blk++;
    if (cyc == LIMIT) begin
      n_errors++;
      $display("mismatch at %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task automatic busy_rise(output int t);
    k = 0;
    while (low_power !== 1'b1 && k < 20000) begin tick(); k++; end
    while (sample_busy !== 1'b1 && k < 20000) begin tick(); k++; end
    t = cyc;
    chk(16'(k < 20000), 16'h1, "no sample start");
  endtask

  task automatic res_wait();
    k = 0;
    tick();
    while (result_valid !== 1'b1 && k < 20000) begin tick(); k++; end
  endtask

  task automatic t_regs();
    rd(OFF_TIMING); chk(16'(rv), 16'(RST_TIMING), "timing reset");
    rd(OFF_HOLD); chk(16'(rv), 16'(RST_HOLD), "hold reset");
    rd(OFF_AVG); chk(16'(rv), 16'(RST_AVG), "avg reset");
    rd(OFF_RECAL); chk(16'(rv), 16'(RST_RECAL), "recal reset");
    rd(8'h25); chk(16'(rv), 16'h0, "unmapped read");
    wr(OFF_TIMING, 8'h5a);
    rd(OFF_TIMING); chk(16'(rv), 16'h5a, "timing rw");
    wr(OFF_HOLD, 8'hff);
    rd(OFF_HOLD); chk(16'(rv), 16'h0f, "hold field width");
    wr(OFF_AVG, 8'hff);
    rd(OFF_AVG); chk(16'(rv), 16'h7f, "avg field width");
  endtask

  // Threshold and repeat both 35 ms, 7000 cycles
  task automatic t_touch();
    wr(OFF_HOLD, 8'h00);
    wr(OFF_TIMING, 8'ha0);
    tick();
    n_irq = 0;
    n_tev = 0;
    pad_press <= 6'h01;
    repeat (3) tick();
    chk(16'(press_irq[0]), 16'h1, "press pulse");
    repeat (100) tick();
    pad_press <= 6'h00;
    repeat (10) tick();
    chk(16'(n_irq == 1 && n_tev == 1), 16'h1, "short touch");
    pad_press <= 6'h01;
    repeat (16000) tick();
    chk(16'(hold_active[0]), 16'h1, "hold class");
    chk(16'(n_irq >= 3), 16'h1, "repeat pulses");
    rd(OFF_HOLDFLAG); chk(16'(rv), 16'h01, "hold flag reg");
    pad_press <= 6'h00;
    repeat (10) tick();
    chk(16'(hold_active[0]), 16'h0, "hold release");
    chk(16'(n_tev), 16'h1, "no touch event after hold");
  endtask

  // One sample 320 us, cycle 35 ms: 64 and 7000 cycles
  task automatic t_scan();
    input_enable <= 6'h05;
    wr(OFF_AVG, 8'h00);
    active_state <= 1'b1;
    busy_rise(t0);
    chk(16'(sample_channel), 16'h0, "first channel");
    k = 0;
    while (sample_busy === 1'b1 && k < 1000) begin tick(); k++; end
    chk(16'(k >= 62 && k <= 66), 16'h1, "sample time");
    if (result_valid !== 1'b1) res_wait();
    chk(16'({result_channel, result_value}), 16'h0100, "ch0 avg");
    res_wait();
    chk(16'({result_channel, result_value}), 16'h0920, "ch2 avg");
    k = 0;
    while (low_power !== 1'b1 && k < 10) begin tick(); k++; end
    chk(16'(low_power), 16'h1, "idle after pass");
    busy_rise(t1);
    chk(16'(t1 - t0 >= 6996 && t1 - t0 <= 7004), 16'h1, "period");
    input_enable <= 6'h3f;
    busy_rise(t0);
    chk(16'(t0 - t1 >= 6996 && t0 - t1 <= 7004), 16'h1, "period");
    // 16 samples of 2.56 ms outlast the 35 ms cycle
    input_enable <= 6'h01;
    wr(OFF_AVG, 8'h4c);
    k = 0;
    while (low_power !== 1'b1 && k < 8000) begin tick(); k++; end
    busy_rise(t0);
    res_wait();
    chk(16'(result_value), 16'h0100, "avg of 16");
    k = 0;
    while (sample_busy !== 1'b1 && k < 20) begin tick(); k++; end
    chk(16'(k < 20), 16'h1, "stretched restart");
  endtask

  task automatic t_idle();
    active_state <= 1'b0;
    k = 0;
    while (low_power !== 1'b1 && k < 20000) begin tick(); k++; end
    t0 = 0;
    repeat (8000) begin
      tick();
      if (sample_busy !== 1'b0) t0 = 1;
    end
    chk(16'(t0), 16'h0, "scan while not active");
  endtask

  // Pad held across the first runs, so they are spoiled; the run after release succeeds
  task automatic t_recal();
    wr(OFF_RECAL, 8'h01);
    tick();
    chk(16'(recal_busy[0]), 16'h1, "recal start");
    rd(OFF_STATUS); chk(16'(rv), 16'h41, "status during recal");
    n_blk = 0;
    pad_press <= 6'h01;
    repeat (60) tick();
    rd(OFF_RECAL); chk(16'(rv), 16'h01, "spoiled run keeps request");
    pad_press <= 6'h00;
    repeat (100) tick();
    rd(OFF_RECAL); chk(16'(rv), 16'h00, "request clears");
    chk(16'(calibration_value[0]), 16'h0100, "cal value");
    chk(16'(n_blk), 16'h0, "press while recal");
  endtask

  initial begin
    reset             = 1'b1;
    reg_addr          = 8'h00;
    reg_wdata         = 8'h00;
    reg_wr            = 1'b0;
    reg_rd            = 1'b0;
    active_state      = 1'b0;
    held_limit_enable = 1'b0;
    input_enable      = 6'h3f;
    repeat_enable     = 6'h3f;
    pad_press         = 6'h00;
    n_errors          = 0;
    n_checks          = 0;
    cyc               = 0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_touch();
    t_scan();
    t_idle();
    t_recal();
    report_and_stop();
  end
endmodule // test_touch_scan_timing_config

// File: sim/touch_pad_model.sv
// Far-side model: six touch pads and the sensing front end.
// Assumes the block samples sample_value on the last cycle of a sample.
`timescale 1ns/1ps

module touch_pad_model
  import touch_scan_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic [NCH-1:0] pad_press,
  input  wire logic           sample_busy,
  input  wire logic [2:0]     sample_channel,
  output logic      [NCH-1:0] touch_raw,
  output logic      [9:0]     sample_value
);
  // Pads are plain contacts, so they reach the block unsynchronised
  assign touch_raw = pad_press;

  initial sample_value = 10'h000;

  // Outside a sample the line is not held, so it toggles every cycle
  always @(posedge mclk) begin
    if (sample_busy)
      sample_value <= 10'h100 + {3'b000, sample_channel, 4'h0};
    else
      sample_value <= ~sample_value;
  end
endmodule // touch_pad_model
